// File: design/psm_merger.sv
`timescale 1ns/1ps
//
// Behaviour
// - search starts after last served input
// - candidates wrap modulo count, served last
// - first non-empty becomes source, word forwarded
// - first word not last enters pass
// - pass forwards only from active source
// - last word returns merger to waiting
// - one word per cycle, arbitration included
// - input count parameter, index clog2 wide
// - reset to waiting, index zero
// - words carry 64 data plus last
module psm_merger
    import psm_pkg::*;
#(
    parameter int N_IN  = psm_pkg::NUM_INPUTS,
    parameter int W     = psm_pkg::DATA_W,
    parameter int DEPTH = psm_pkg::FIFO_DEPTH
) (
    input  wire logic              MCLK,
    input  wire logic              RESETN,
    input  wire logic [N_IN*W-1:0] IN_DATA,
    input  wire logic [N_IN-1:0]   IN_LAST,
    input  wire logic [N_IN-1:0]   IN_VALID,
    output logic [N_IN-1:0]        IN_READY,
    output logic [W-1:0]           OUT_DATA,
    output logic                   OUT_LAST,
    output logic                   OUT_VALID,
    input  wire logic              OUT_READY
);
    import psm_pkg::*;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    // index width
    localparam int source_index_width = (N_IN > 1) ? $clog2(N_IN) : 1;
    localparam int FW                 = W + 1;

    psm_state_t                    merger_state_q;
    psm_state_t                    merger_state_d;
    logic [source_index_width-1:0] active_source_index_q;
    logic [source_index_width-1:0] active_source_index_d;
    logic [N_IN-1:0]               take;
    logic                          fwd;
    logic [W-1:0]                  sel_data;
    logic                          sel_last;
    logic                          mo_ready;

    // merged output goes through the buffer
    psm_stream_if #(.W(W)) merged_output_stream ();

    // ------------------------------------------------------------
    // candidate wrap
    // ------------------------------------------------------------
    // modulo wrap
    function automatic logic [source_index_width-1:0] wrap_idx(
        input int unsigned base,
        input int unsigned step
    );
        int unsigned s;
        s = base + step;
        if (s >= N_IN) begin
            s = s - N_IN;
        end
        wrap_idx = source_index_width'(s);
    endfunction

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    // the full search is one combinational pass, so arbitration costs
    // no bubble; the price is a priority chain N_IN deep
    always_comb begin
        logic [source_index_width-1:0] candidate_index;
        logic                          found;
        candidate_index       = '0;
        found                 = 1'b0;
        take                  = '0;
        fwd                   = 1'b0;
        sel_data              = '0;
        sel_last              = 1'b0;
        merger_state_d        = merger_state_q;
        active_source_index_d = active_source_index_q;
        unique case (merger_state_q)
            PSM_WAIT: begin
                for (int i = 0; i < N_IN; i++) begin
                    candidate_index = wrap_idx(int'(active_source_index_q), 1 + i);
                    if (!found && IN_VALID[candidate_index] && mo_ready) begin
                        found                 = 1'b1;
                        active_source_index_d = candidate_index;
                    end
                end
                if (found) begin
                    take[active_source_index_d] = 1'b1;
                    fwd      = 1'b1;
                    sel_data = IN_DATA[active_source_index_d*W +: W];
                    sel_last = IN_LAST[active_source_index_d];
                    if (!sel_last) begin
                        merger_state_d = PSM_PASS;
                    end
                end
            end
            PSM_PASS: begin
                if (IN_VALID[active_source_index_q] && mo_ready) begin
                    take[active_source_index_q] = 1'b1;
                    fwd      = 1'b1;
                    sel_data = IN_DATA[active_source_index_q*W +: W];
                    sel_last = IN_LAST[active_source_index_q];
                    if (sel_last) begin
                        merger_state_d = PSM_WAIT;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // reset state
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            merger_state_q        <= PSM_WAIT;
            active_source_index_q <= source_index_width'(SRC_RESET);
        end else begin
            merger_state_q        <= merger_state_d;
            active_source_index_q <= active_source_index_d;
        end
    end

    // ------------------------------------------------------------
    // input ready
    // ------------------------------------------------------------
    // one word per cycle
    assign IN_READY = take;

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    // word is data plus last
    assign merged_output_stream.data  = sel_data;
    assign merged_output_stream.last  = sel_last;
    assign merged_output_stream.valid = fwd;
    // no grant while reset is held, whatever the producers show
    assign mo_ready                   = merged_output_stream.ready && RESETN;

    logic [FW-1:0] buf_data;
    logic          buf_valid;
    logic          buf_ready;

    psm_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst_n     (RESETN),
        .in_data   ({merged_output_stream.last, merged_output_stream.data}),
        .in_valid  (merged_output_stream.valid),
        .in_ready  (merged_output_stream.ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    // ------------------------------------------------------------
    // registered output stage
    // ------------------------------------------------------------
    // skid-free register: refills whenever empty or being consumed
    assign buf_ready = !OUT_VALID || OUT_READY;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            OUT_VALID <= 1'b0;
            OUT_DATA  <= '0;
            OUT_LAST  <= 1'b0;
        end else if (buf_ready) begin
            OUT_VALID <= buf_valid;
            // data only moves with a word, so an idle output never shows unwritten storage
            if (buf_valid) begin
                OUT_DATA <= buf_data[W-1:0];
                OUT_LAST <= buf_data[W];
            end
        end
    end
endmodule

// File: design/psm_pkg.sv
package psm_pkg;
    // word format shared by inputs and output
    localparam int DATA_W      = 64;
    localparam int NUM_INPUTS  = 4;
    localparam int FIFO_DEPTH  = 8;
    localparam int SRC_RESET   = 0;

    typedef enum logic {
        PSM_WAIT,
        PSM_PASS
    } psm_state_t;
endpackage

// File: design/psm_stream_if.sv
`timescale 1ns/1ps
// one packet word channel: data, last flag, valid and ready
interface psm_stream_if #(
    parameter int W = 64
);
    logic [W-1:0] data;
    logic         last;
    logic         valid;
    logic         ready;

    modport src (output data, output last, output valid, input ready);
    modport dst (input data, input last, input valid, output ready);
endinterface

// File: design/psm_fifo.sv
`timescale 1ns/1ps
module psm_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // pointer wrap, used for both ends
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage needs no reset, only the pointers and the count do
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= nxt(wr_q);
            end
            if (pop) begin
                rd_q <= nxt(rd_q);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: tb/psm_monitor.sv
`timescale 1ns/1ps
// ----------
// merger port checker
// ----------
module psm_monitor #(
    parameter int N_IN = 4
) (
    input wire logic            MCLK,
    input wire logic            RESETN,
    input wire logic [N_IN-1:0] IN_LAST,
    input wire logic [N_IN-1:0] IN_VALID,
    input wire logic [N_IN-1:0] IN_READY,
    input wire logic [63:0]     OUT_DATA,
    input wire logic            OUT_LAST,
    input wire logic            OUT_VALID,
    input wire logic            OUT_READY
);
    int   src_q, pick, rr;
    logic lock_q;
    // scan from the far end so the first search step wins
    always_comb begin
        pick = 0;
        rr = 0;
        for (int i = N_IN; i > 0; i--) begin
            if (IN_READY[i-1]) pick = i - 1;
            if (IN_VALID[(src_q+i)%N_IN]) rr = (src_q + i) % N_IN;
        end
    end
    // last served input and packet lock
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            src_q  <= 0;
            lock_q <= 1'h0;
        end else if (|IN_READY) begin
            src_q  <= pick;
            lock_q <= !IN_LAST[pick];
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_one_grant: assert property ($onehot0(IN_READY))
        else $error("two grants");
    a_grant_valid: assert property ((IN_READY & ~IN_VALID) == '0)
        else $error("idle grant");
    a_lock_src: assert property (lock_q && |IN_READY |-> IN_READY[src_q])
        else $error("lock lost");
    a_rr_order: assert property (!lock_q && |IN_READY |-> pick == rr)
        else $error("search order");
    a_no_bubble: assert property (!OUT_VALID && !$past(OUT_VALID)
        && (lock_q ? IN_VALID[src_q] : |IN_VALID) |-> |IN_READY) else $error("bubble");
    a_out_latency: assert property (|IN_READY && !OUT_VALID
        && !$past(OUT_VALID) |-> ##[1:2] OUT_VALID) else $error("late word");
    a_out_hold: assert property (OUT_VALID && !OUT_READY
        |=> OUT_VALID && $stable({OUT_LAST, OUT_DATA})) else $error("word moved");
    a_reset_quiet: assert property (disable iff (1'h0)
        !RESETN |-> !OUT_VALID && IN_READY == '0) else $error("busy in reset");
    c_locked: cover property (lock_q && |IN_READY);
    c_full: cover property (OUT_VALID && !OUT_READY && |IN_VALID && IN_READY == '0);
    c_wrap: cover property (!lock_q && |IN_READY && pick == 0);
endmodule
bind psm_merger psm_monitor #(.N_IN(N_IN)) mon_u (.MCLK(MCLK), .RESETN(RESETN),
    .IN_LAST(IN_LAST), .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_DATA(OUT_DATA),
    .OUT_LAST(OUT_LAST), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));

// File: tb/psm_sink.sv
`timescale 1ns/1ps
// ----------
// consumer: takes all, every other cycle, or none
// ----------
module psm_sink (
    input  wire logic        clk,
    input  wire logic [1:0]  mode,
    input  wire logic [63:0] data,
    input  wire logic        last,
    input  wire logic        valid,
    output logic             ready = 1'h0
);
    logic [64:0] got[$];
    logic        odd = 1'h0;
    // consumer may stall
    // ready moves on the falling edge only
    always @(negedge clk) begin
        odd = ~odd;
        ready = mode == 2'h0 || (mode == 2'h1 && odd);
    end
    // data plus last flag
    // keep each word handed over
    always @(posedge clk) if (valid && ready) got.push_back({last, data});
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
// ----------
// queues feed the inputs, the sink model drains
// ----------
module testbench;
    import psm_pkg::*;
    logic          MCLK = 1'h0;
    logic          rst_n = 1'h0;
    logic [255:0]  in_data = '0;
    logic [3:0]    in_last = '0, in_valid = '0, in_ready, taken = '0;
    logic [63:0]   out_data;
    logic          out_last, out_valid, out_ready;
    logic [1:0]    mode = 2'h0;
    logic [64:0]   srcq[4][$];
    logic [64:0]   expq[$];
    int            err_total = 0;
    int            comparisons = 0;
    psm_merger dut_u (.MCLK(MCLK), .RESETN(rst_n), .IN_DATA(in_data), .IN_LAST(in_last),
        .IN_VALID(in_valid), .IN_READY(in_ready), .OUT_DATA(out_data), .OUT_LAST(out_last),
        .OUT_VALID(out_valid), .OUT_READY(out_ready));
    psm_sink sink_u (.clk(MCLK), .mode(mode), .data(out_data), .last(out_last),
        .valid(out_valid), .ready(out_ready));
    initial forever #2.5 MCLK = ~MCLK;
    // packets sent whole
    // pop what was taken; an idle line toggles so it never looks held
    always @(posedge MCLK) taken <= in_valid & in_ready;
    always @(negedge MCLK) begin
        for (int i = 0; i < 4; i++) begin
            if (taken[i]) void'(srcq[i].pop_front());
            in_valid[i] = srcq[i].size() != 0;
            in_data[i*64 +: 64] = in_valid[i] ? srcq[i][0][63:0] : ~in_data[i*64 +: 64];
            in_last[i] = in_valid[i] ? srcq[i][0][64] : 1'h0;
        end
    end
    task automatic chk(input logic [64:0] seen, input logic [64:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait for every expected word, then compare in order
    task automatic drain(input string what);
        for (int n = 0; n < 300 && sink_u.got.size() < expq.size(); n++) @(negedge MCLK);
        chk(65'(sink_u.got.size()), 65'(expq.size()), "count");
        foreach (expq[j]) chk(sink_u.got[j], expq[j], "word");
        sink_u.got.delete();
        expq.delete();
        $display("%s done", what);
    endtask
    // single-word packets on all inputs at once, taken one per cycle
    task automatic t_rr();
        int n = 0;
        @(posedge MCLK);
        for (int k = 0; k < 8; k++) begin
            srcq[k%4].push_back({1'h1, 64'(k)});
            expq.push_back({1'h1, 64'((k + 1) % 4 + k / 4 * 4)});
        end
        // pushed between edges, so the words show at the next falling edge
        @(negedge MCLK);
        repeat (8) begin
            @(negedge MCLK);
            n += $countones(taken);
        end
        chk(65'(n), 65'h8, "back to back");
        drain("rr");
    endtask
    // three-word packet holds off the others
    task automatic t_lock();
        for (int k = 0; k < 3; k++) srcq[1].push_back({1'(k == 2), 64'(16 + k)});
        srcq[2].push_back({1'h1, 64'h20});
        srcq[0].push_back({1'h1, 64'h0});
        expq = {srcq[1], srcq[2], srcq[0]};
        drain("lock");
    endtask
    // stalled consumer until the buffer refuses, then a slow drain
    task automatic t_stall();
        mode = 2'h2;
        for (int k = 0; k < 16; k++) srcq[3].push_back({1'(k == 15), 64'(k)});
        expq = srcq[3];
        repeat (30) @(negedge MCLK);
        chk(65'({in_valid, in_ready}), 65'h80, "refused");
        mode = 2'h1;
        drain("stall");
    endtask
    // reset in mid-run: nothing taken while held, search restarts at input 1
    task automatic t_reset();
        rst_n = 1'h0;
        srcq[0].push_back({1'h1, 64'h30});
        srcq[2].push_back({1'h1, 64'h32});
        expq = {srcq[2], srcq[0]};
        repeat (3) @(negedge MCLK);
        chk(65'({out_valid, in_ready}), 65'h0, "reset quiet");
        rst_n = 1'h1;
        drain("reset");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(negedge MCLK);
        rst_n = 1'h1;
        t_rr();
        t_lock();
        t_stall();
        t_reset();
        tally_and_finish();
    end
    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        #10000;
        err_total++;
        tally_and_finish();
    end
endmodule
